// file: scope_defs.svh
// Operation
// [RULE1] Start fills pretrigger, keeps sampling awaiting trigger
// [RULE2] After trigger fill record, hand to display
// [RULE3] Edge/pulse trigger events counted into frequency
// [RULE4] Source channel, external or line; line edge-only
// [RULE5] Exactly one of edge, video, pulse width
// [RULE6] Trigger mode auto or normal; single-shot command
// [RULE7] Coupling alters trigger path only, not data
// [RULE8] Trigger view routes conditioned trigger to display
// [RULE9] Horizontal position sets pretrigger/posttrigger split
// [RULE10] Edge slope selects rising or falling edge
// [RULE11] Level threshold declares trigger point
// [RULE12] Sample mode keeps one value per interval
// [RULE13] Peak mode keeps max and min per interval
// [RULE14] Average mode shows point-wise mean of records
// [RULE15] One shared time base for all channels
// [RULE16] Maximum rate 1 or 2 GS/s by bandwidth
// [RULE17] Sample rate follows time base proportionally
// [RULE18] Record length fixed at 2500 points
// [RULE19] Armed ignores triggers; ready accepts them
// [RULE20] Auto mode keeps acquiring without triggers
// [RULE21] Single shot stops after one record, completes
// [RULE22] Normal mode needs a trigger per record
`ifndef SCOPE_DEFS_SVH
`define SCOPE_DEFS_SVH

`define RECORD_LEN 12'h9c4
`define REG_CTRL 8'h00
`define REG_LEVEL 8'h04
`define REG_TIMEBASE 8'h08
`define REG_HPOS 8'h0c
`define REG_PWIDTH 8'h10
`define REG_CMD 8'h14
`define REG_STATUS 8'h18
`define REG_TFREQ 8'h1c
`define REG_RATE 8'h20

`define CTRL_NORMAL_BIT 0
`define CTRL_TYPE_HI 2
`define CTRL_TYPE_LO 1
`define CTRL_SRC_HI 4
`define CTRL_SRC_LO 3
`define CTRL_SLOPE_BIT 5
`define CTRL_LPF_BIT 6
`define CTRL_ACQ_HI 8
`define CTRL_ACQ_LO 7
`define CTRL_AVG_HI 11
`define CTRL_AVG_LO 9
`define CTRL_FIELD_BIT 12
`define CTRL_W 13
`define CMD_RUN_BIT 0
`define CMD_SINGLE_BIT 1
`define CMD_STOP_BIT 2

`define CTRL_RST 13'h0000
`define LEVEL_RST 8'h80
`define TB_RST 16'h0001
`define HPOS_RST 12'h4e2
`define HPOS_MAX 12'h9c3
`define PWIDTH_RST 16'h0010
`define VID_LINE_MIN 16'h0004
`define VID_FIELD_MIN 16'h0040

`define CLK_HZ 25000000
`define AUTO_WAIT_MS 100
`define TFREQ_GATE_MS 1000
`define MAX_RATE_MSPS_LOW_BW 1000
`define MAX_RATE_MSPS_HIGH_BW 2000
`define HIGH_BW_MHZ 200

`endif

// file: scope_pkg.sv
package scope_pkg;
    typedef enum logic [5:0] {
        ST_STOP  = 6'b000001,
        ST_ARMED = 6'b000010,
        ST_READY = 6'b000100,
        ST_TRIGD = 6'b001000,
        ST_FOLD  = 6'b010000,
        ST_DONE  = 6'b100000
    } acq_state_e;
    typedef enum logic [1:0] {
        TT_EDGE = 2'h0,
        TT_VIDEO = 2'h1,
        TT_PULSE = 2'h2
    } trig_type_e;
    typedef enum logic [1:0] {
        SRC_CH0 = 2'h0,
        SRC_CH1 = 2'h1,
        SRC_EXT = 2'h2,
        SRC_LINE = 2'h3
    } trig_src_e;
    typedef enum logic [1:0] {
        AM_SAMPLE = 2'h0,
        AM_PEAK = 2'h1,
        AM_AVG = 2'h2
    } acq_mode_e;
endpackage : scope_pkg

// file: pin_sync.sv
`timescale 1ns/1ns
module pin_sync #(
    parameter int W = 1
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic [W-1:0] pin,
    output logic [W-1:0] synced
);
    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] stable;
    } sync_s;
    sync_s s_q;
    sync_s s_d;

    // First stage feeds only the second
    always_comb
    begin
        s_d.meta = pin;
        s_d.stable = s_q.meta;
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            s_q <= '0;
        else
            s_q <= s_d;
    end

    assign synced = s_q.stable;
endmodule : pin_sync

// file: interval_peak.sv
`timescale 1ns/1ns
module interval_peak (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic valid,
    input wire logic first,
    input wire logic last,
    input wire logic [7:0] data,
    output logic [7:0] pmax,
    output logic [7:0] pmin,
    output logic [7:0] psamp,
    output logic pdone
);
    typedef struct packed {
        logic [7:0] hi;
        logic [7:0] lo;
        logic [7:0] samp;
        logic done;
    } peak_s;
    peak_s s_q;
    peak_s s_d;

    // Extremes restart on the first sample of each interval
    always_comb
    begin
        s_d = s_q;
        s_d.done = valid && last;
        if (valid)
        begin
            s_d.hi = (first || data > s_q.hi) ? data : s_q.hi; // RULE13
            s_d.lo = (first || data < s_q.lo) ? data : s_q.lo; // RULE13
            if (first)
                s_d.samp = data; // RULE12
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            s_q <= '0;
        else
            s_q <= s_d;
    end

    assign pmax = s_q.hi;
    assign pmin = s_q.lo;
    assign psamp = s_q.samp;
    assign pdone = s_q.done;
endmodule : interval_peak

// file: scope_trigger_acquisition_ctrl.sv
`timescale 1ns/1ns
`include "scope_defs.svh"
module scope_trigger_acquisition_ctrl
    import scope_pkg::*;
#(
    parameter int AUTO_WAIT_CYCLES = `CLK_HZ / 1000 * `AUTO_WAIT_MS,
    parameter int TFREQ_GATE_CYCLES = `CLK_HZ / 1000 * `TFREQ_GATE_MS,
    parameter int BANDWIDTH_MHZ = 100
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic adc_valid,
    input wire logic [7:0] adc_ch0,
    input wire logic [7:0] adc_ch1,
    input wire logic external_trigger_input,
    input wire logic line_sync,
    input wire logic trigger_path_view,
    input wire logic [11:0] disp_addr,
    output logic [31:0] disp_data,
    output logic rec_ready
);
    localparam logic [15:0] RATE_MSPS = (BANDWIDTH_MHZ >= `HIGH_BW_MHZ) ?
        16'(`MAX_RATE_MSPS_HIGH_BW) : 16'(`MAX_RATE_MSPS_LOW_BW); // RULE16

    typedef struct packed {
        acq_state_e state;
        logic [`CTRL_W-1:0] ctrl;
        logic [7:0] level;
        logic [15:0] tb;
        logic [11:0] hpos;
        logic [15:0] pwidth;
        logic run;
        logic single;
        logic complete;
        logic wr_pend;
        logic rd_pend;
        logic [7:0] addr;
        logic [31:0] rdata;
        logic [15:0] div_cnt;
        logic [11:0] wptr;
        logic [11:0] cnt;
        logic [24:0] auto_cnt;
        logic [7:0] avg_cnt;
        logic [11:0] fold_idx;
        logic [11:0] rec_start;
        logic [7:0] src_prev;
        logic comp_prev;
        logic [15:0] pw_cnt;
        logic [24:0] gate_cnt;
        logic [23:0] ev_cnt;
        logic [23:0] tfreq;
        logic [31:0] disp;
        logic ready_pulse;
    } ctl_s;
    ctl_s s_q;
    ctl_s s_d;

    logic [31:0] rec_mem [0:2499];
    logic [31:0] avg_mem [0:2499];
    logic rec_we;
    logic [11:0] rec_waddr;
    logic [31:0] rec_wdata;
    logic avg_we;
    logic [11:0] avg_waddr;
    logic [31:0] avg_wdata;
    logic [2:0] pins_s;
    logic [7:0] max0, min0, smp0, max1, min1, smp1;
    logic pdone0;
    logic interval_first;
    logic interval_last;

    // Front-panel and external pins are asynchronous to hclk
    pin_sync #(.W(3)) u_pins (
        .hclk(hclk),
        .hresetn(hresetn),
        .pin({trigger_path_view, line_sync, external_trigger_input}),
        .synced(pins_s)
    );

    // One divider drives every channel's interval
    assign interval_first = (s_q.div_cnt == 16'h0000); // RULE15
    assign interval_last = (s_q.div_cnt >= s_q.tb - 16'h0001); // RULE17

    interval_peak u_ch0 (
        .hclk(hclk),
        .hresetn(hresetn),
        .valid(adc_valid),
        .first(interval_first),
        .last(interval_last),
        .data(adc_ch0),
        .pmax(max0),
        .pmin(min0),
        .psamp(smp0),
        .pdone(pdone0)
    );
    interval_peak u_ch1 (
        .hclk(hclk),
        .hresetn(hresetn),
        .valid(adc_valid),
        .first(interval_first),
        .last(interval_last),
        .data(adc_ch1),
        .pmax(max1),
        .pmin(min1),
        .psamp(smp1),
        .pdone()
    );

    // Wrap a record offset into the circular buffer
    function automatic logic [11:0] wrap(input logic [11:0] a,
                                         input logic [11:0] b);
        logic [12:0] sum;
        sum = {1'b0, a} + {1'b0, b};
        if (sum >= {1'b0, `RECORD_LEN})
            sum = sum - {1'b0, `RECORD_LEN};
        return sum[11:0];
    endfunction : wrap

    trig_type_e ttype;
    trig_src_e tsrc;
    acq_mode_e amode;
    logic [7:0] src_smp;
    logic [7:0] cond;
    logic comp;
    logic pol;
    logic event_hit;
    logic pw_end;
    logic [15:0] vid_min;
    logic [11:0] post_len;
    logic [15:0] avg_den;
    logic [31:0] rec_rd;
    logic [31:0] avg_rd;
    logic [31:0] fold_src;
    logic [15:0] sum0, sum1;
    logic wr_go, rd_go;

    always_comb
    begin
        ttype = trig_type_e'(s_q.ctrl[`CTRL_TYPE_HI:`CTRL_TYPE_LO]);
        tsrc = trig_src_e'(s_q.ctrl[`CTRL_SRC_HI:`CTRL_SRC_LO]);
        amode = acq_mode_e'(s_q.ctrl[`CTRL_ACQ_HI:`CTRL_ACQ_LO]);
        pol = s_q.ctrl[`CTRL_SLOPE_BIT];
        post_len = `RECORD_LEN - s_q.hpos; // RULE9
        avg_den = 16'h0001 << s_q.ctrl[`CTRL_AVG_HI:`CTRL_AVG_LO];
        vid_min = s_q.ctrl[`CTRL_FIELD_BIT] ? `VID_FIELD_MIN : `VID_LINE_MIN;
        // Source mux; digital pins map to full scale
        unique case (tsrc) // RULE4
            SRC_CH0: src_smp = adc_ch0;
            SRC_CH1: src_smp = adc_ch1;
            SRC_EXT: src_smp = {8{pins_s[0]}};
            SRC_LINE: src_smp = {8{pins_s[1]}};
        endcase
        // Low-pass coupling filters only this copy, never stored data
        cond = s_q.ctrl[`CTRL_LPF_BIT] ?
            8'((({1'b0, src_smp} + {1'b0, s_q.src_prev}) >> 1)) :
            src_smp; // RULE7
        comp = (cond >= s_q.level); // RULE11
        pw_end = (s_q.comp_prev == ~pol) && (comp == pol);
        unique case (ttype) // RULE5
            TT_VIDEO: event_hit = !s_q.comp_prev && comp
                && (s_q.pw_cnt >= vid_min);
            TT_PULSE: event_hit = (s_q.comp_prev != comp) && pw_end
                && (s_q.pw_cnt >= s_q.pwidth);
            default: event_hit = pol ? (s_q.comp_prev && !comp)
                : (!s_q.comp_prev && comp); // RULE10
        endcase
        event_hit = event_hit && adc_valid;
        rec_rd = rec_mem[wrap(s_q.rec_start, disp_addr)];
        avg_rd = avg_mem[disp_addr];
        fold_src = rec_mem[wrap(s_q.rec_start, s_q.fold_idx)];
        sum0 = (s_q.avg_cnt == 8'h00) ? 16'h0000 : avg_mem[s_q.fold_idx][15:0];
        sum1 = (s_q.avg_cnt == 8'h00) ? 16'h0000
            : avg_mem[s_q.fold_idx][31:16];
        wr_go = hsel && hready && htrans[1] && hwrite;
        rd_go = hsel && hready && htrans[1] && !hwrite;
    end

    // Bus slave, trigger path and acquisition sequencer
    always_comb
    begin
        s_d = s_q;
        s_d.ready_pulse = 1'b0;
        rec_we = 1'b0;
        rec_waddr = s_q.wptr;
        rec_wdata = 32'h0000_0000;
        avg_we = 1'b0;
        avg_waddr = s_q.fold_idx;
        avg_wdata = {sum1 + {8'h00, fold_src[23:16]},
                     sum0 + {8'h00, fold_src[7:0]}}; // RULE14
        // Writes land in the data phase; reads wait one cycle
        s_d.wr_pend = wr_go;
        s_d.rd_pend = rd_go;
        if (wr_go || rd_go)
            s_d.addr = haddr[7:0];
        if (s_q.rd_pend)
        begin
            unique case (s_q.addr)
                `REG_CTRL: s_d.rdata = {19'h0, s_q.ctrl};
                `REG_LEVEL: s_d.rdata = {24'h0, s_q.level};
                `REG_TIMEBASE: s_d.rdata = {16'h0, s_q.tb};
                `REG_HPOS: s_d.rdata = {20'h0, s_q.hpos};
                `REG_PWIDTH: s_d.rdata = {16'h0, s_q.pwidth};
                `REG_STATUS: s_d.rdata = {24'h0, s_q.complete,
                    s_q.run, s_q.state};
                `REG_TFREQ: s_d.rdata = {8'h0, s_q.tfreq};
                `REG_RATE: s_d.rdata = {16'h0, RATE_MSPS};
                default: s_d.rdata = 32'h0000_0000;
            endcase
        end
        if (s_q.wr_pend)
        begin
            unique case (s_q.addr)
                `REG_CTRL:
                begin
                    s_d.ctrl = hwdata[`CTRL_W-1:0];
                    // Line source is refused unless edge triggering
                    if (hwdata[`CTRL_SRC_HI:`CTRL_SRC_LO] == SRC_LINE
                        && hwdata[`CTRL_TYPE_HI:`CTRL_TYPE_LO] != TT_EDGE)
                        s_d.ctrl[`CTRL_SRC_HI:`CTRL_SRC_LO] = SRC_CH0; // RULE4
                end
                `REG_LEVEL: s_d.level = hwdata[7:0];
                `REG_TIMEBASE: s_d.tb = (hwdata[15:0] == 16'h0000) ?
                    16'h0001 : hwdata[15:0];
                `REG_HPOS: s_d.hpos = (hwdata[11:0] > `HPOS_MAX) ?
                    `HPOS_MAX : hwdata[11:0];
                `REG_PWIDTH: s_d.pwidth = hwdata[15:0];
                `REG_CMD:
                begin
                    if (hwdata[`CMD_STOP_BIT])
                    begin
                        s_d.run = 1'b0;
                        s_d.state = ST_STOP;
                    end
                    else if (hwdata[`CMD_RUN_BIT] || hwdata[`CMD_SINGLE_BIT])
                    begin
                        s_d.run = 1'b1;
                        s_d.single = hwdata[`CMD_SINGLE_BIT]; // RULE6
                        s_d.complete = 1'b0;
                        s_d.state = ST_ARMED; // RULE1
                        s_d.cnt = 12'h000;
                        s_d.avg_cnt = 8'h00;
                    end
                end
                default: ;
            endcase
        end
        // Trigger path history, pulse width and video sync width
        if (adc_valid)
        begin
            s_d.src_prev = src_smp;
            s_d.comp_prev = comp;
            if (comp != s_q.comp_prev)
                s_d.pw_cnt = 16'h0001;
            else if (s_q.pw_cnt != 16'hffff)
                s_d.pw_cnt = s_q.pw_cnt + 16'h0001;
        end
        // Frequency gate counts edge and pulse events only
        if (s_q.gate_cnt >= 25'(TFREQ_GATE_CYCLES - 1))
        begin
            s_d.gate_cnt = 25'h0;
            s_d.tfreq = s_q.ev_cnt; // RULE3
            s_d.ev_cnt = 24'h0;
        end
        else
        begin
            s_d.gate_cnt = s_q.gate_cnt + 25'h1;
            if (event_hit && ttype != TT_VIDEO)
                s_d.ev_cnt = s_q.ev_cnt + 24'h1; // RULE3
        end
        // Interval divider, shared by both channels
        if (adc_valid)
            s_d.div_cnt = interval_last ? 16'h0000 : s_q.div_cnt + 16'h0001;
        if (pdone0 && (s_q.state == ST_ARMED || s_q.state == ST_READY
            || s_q.state == ST_TRIGD))
        begin
            rec_we = 1'b1; // RULE18
            rec_wdata = (amode == AM_PEAK) ?
                {max1, min1, max0, min0} : // RULE13
                {8'h00, smp1, 8'h00, smp0}; // RULE12
            s_d.wptr = wrap(s_q.wptr, 12'h001);
        end
        unique case ((s_d.state == ST_STOP) ? ST_STOP : s_q.state) // Stop wins
            ST_ARMED:
            begin
                // Triggers are ignored until the pretrigger is full
                if (s_q.cnt >= s_q.hpos)
                begin
                    s_d.state = ST_READY; // RULE19
                    s_d.auto_cnt = 25'h0;
                end
                else if (rec_we)
                    s_d.cnt = s_q.cnt + 12'h001; // RULE1
            end
            ST_READY:
            begin
                s_d.auto_cnt = s_q.auto_cnt + 25'h1;
                if (event_hit) // RULE19
                begin
                    s_d.state = ST_TRIGD;
                    s_d.cnt = 12'h000;
                end
                else if (!s_q.ctrl[`CTRL_NORMAL_BIT]
                    && s_q.auto_cnt >= 25'(AUTO_WAIT_CYCLES - 1))
                begin
                    s_d.state = ST_TRIGD; // RULE20
                    s_d.cnt = 12'h000;
                end // RULE22
            end
            ST_TRIGD:
            begin
                if (rec_we)
                    s_d.cnt = s_q.cnt + 12'h001;
                if (s_q.cnt >= post_len)
                begin
                    s_d.rec_start = s_d.wptr; // RULE2
                    s_d.fold_idx = 12'h000;
                    s_d.state = ST_FOLD;
                end
            end
            ST_FOLD:
            begin
                // Running sum of records; outside averaging, a copy of record bytes 0 and 2
                avg_we = 1'b1;
                s_d.fold_idx = s_q.fold_idx + 12'h001;
                if (s_q.fold_idx == `RECORD_LEN - 12'h001)
                begin
                    s_d.avg_cnt = s_q.avg_cnt + 8'h01;
                    s_d.cnt = 12'h000;
                    if (amode == AM_AVG
                        && {8'h00, s_d.avg_cnt} < avg_den)
                        s_d.state = ST_ARMED; // RULE14
                    else
                    begin
                        s_d.avg_cnt = 8'h00;
                        s_d.ready_pulse = 1'b1; // RULE2
                        if (s_q.single)
                        begin
                            s_d.state = ST_DONE; // RULE21
                            s_d.complete = 1'b1;
                            s_d.run = 1'b0;
                        end
                        else
                            s_d.state = ST_ARMED; // RULE20
                    end
                end
            end
            ST_STOP, ST_DONE: ;
            default: s_d.state = ST_STOP;
        endcase
        // Display read; trigger view replaces the waveform
        if (pins_s[2])
            s_d.disp = {24'h000000, cond}; // RULE8
        else if (amode == AM_AVG)
            s_d.disp = {8'h00, 8'(avg_rd[31:16] >>
                s_q.ctrl[`CTRL_AVG_HI:`CTRL_AVG_LO]),
                8'h00, 8'(avg_rd[15:0] >>
                s_q.ctrl[`CTRL_AVG_HI:`CTRL_AVG_LO])}; // RULE14
        else
            s_d.disp = rec_rd;
    end

    // Record and average memories
    always_ff @(posedge hclk)
    begin
        if (rec_we)
            rec_mem[rec_waddr] <= rec_wdata;
        if (avg_we)
            avg_mem[avg_waddr] <= avg_wdata;
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            s_q <= '0;
            s_q.state <= ST_STOP;
            s_q.ctrl <= `CTRL_RST;
            s_q.level <= `LEVEL_RST;
            s_q.tb <= `TB_RST;
            s_q.hpos <= `HPOS_RST;
            s_q.pwidth <= `PWIDTH_RST;
        end
        else
            s_q <= s_d;
    end

    assign hrdata = s_q.rdata;
    assign hreadyout = !s_q.rd_pend; // Reads take one wait state
    assign hresp = 1'b0;
    assign disp_data = s_q.disp;
    assign rec_ready = s_q.ready_pulse;
endmodule : scope_trigger_acquisition_ctrl

// file: front_end_model.sv
`timescale 1ns/1ns
module front_end_model (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic wave_on,
    output logic adc_valid,
    output logic [7:0] adc_ch0,
    output logic [7:0] adc_ch1,
    output logic external_trigger_input,
    output logic line_sync
);
    logic [4:0] ph_q;

    // Digitizer: one sample a cycle, 32-sample square wave when enabled
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            ph_q <= 5'h00;
            adc_valid <= 1'b0;
            adc_ch0 <= 8'h10;
            adc_ch1 <= 8'hef;
            external_trigger_input <= 1'b0;
            line_sync <= 1'b0;
        end
        else
        begin
            ph_q <= ph_q + 5'h01;
            adc_valid <= 1'b1;
            adc_ch0 <= (wave_on && ph_q[4]) ? 8'hf0 : 8'h10;
            // Inverse of ch0, so a swapped channel is easy to spot
            adc_ch1 <= (wave_on && ph_q[4]) ? 8'h0f : 8'hef;
            external_trigger_input <= ph_q[4];
            line_sync <= ph_q[3];
        end
    end
endmodule : front_end_model

// file: acq_props.sv
`timescale 1ns/1ns
module acq_props (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic trigger_path_view,
    input wire logic [31:0] disp_data,
    input wire logic rec_ready
);
    localparam int FOLD_LEN = 2500;
    logic [11:0] gap_q;

    // Cycles since the last record; saturates so it never wraps
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            gap_q <= 12'hfff;
        else if (rec_ready)
            gap_q <= 12'h000;
        else if (gap_q != 12'hfff)
            gap_q <= gap_q + 12'h001;
    end

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    sequence rd_req;
        hsel && hready && htrans[1] && !hwrite;
    endsequence
    sequence wr_req;
        hsel && hready && htrans[1] && hwrite;
    endsequence

    ok_resp_a: assert property (hresp == 1'b0)
        else $error("hresp not okay");
    read_stall_a: assert property (rd_req |=> !hreadyout ##1 hreadyout)
        else $error("read wait state wrong");
    write_fast_a: assert property (wr_req |=> hreadyout)
        else $error("write stalled");
    stall_cause_a: assert property (!hreadyout
        |-> $past(hsel && hready && htrans[1] && !hwrite))
        else $error("stall without read");
    rdata_hold_a: assert property ($changed(hrdata) |-> !$past(hreadyout))
        else $error("hrdata moved outside read");
    rec_pulse_a: assert property (rec_ready |=> !rec_ready)
        else $error("record strobe too long");
    rec_gap_a: assert property (rec_ready |-> gap_q >= FOLD_LEN)
        else $error("records too close");
    view_route_a: assert property (
        trigger_path_view [*4] |=> disp_data[31:8] == 24'h0)
        else $error("trigger view not routed");
endmodule : acq_props

bind scope_trigger_acquisition_ctrl acq_props u_props (.hclk(hclk),
    .hresetn(hresetn), .hsel(hsel), .htrans(htrans), .hwrite(hwrite),
    .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .trigger_path_view(trigger_path_view), .disp_data(disp_data),
    .rec_ready(rec_ready));

// file: testbench.sv
`timescale 1ns/1ns
`include "scope_defs.svh"
module testbench;
    logic hclk, hresetn, hwrite, trigger_path_view, wave_on, seen;
    logic hreadyout, hresp, adc_valid, ext_pin, line_pin, rec_ready;
    logic [1:0] htrans;
    logic [31:0] haddr, hwdata, hrdata, disp_data, rd;
    logic [11:0] disp_addr;
    logic [7:0] ch0, ch1;
    int fails, checks_done, cycles, recs;

    scope_trigger_acquisition_ctrl #(.AUTO_WAIT_CYCLES(200),
        .TFREQ_GATE_CYCLES(1000), .BANDWIDTH_MHZ(100)) dut (.hclk(hclk),
        .hresetn(hresetn), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .adc_valid(adc_valid), .adc_ch0(ch0), .adc_ch1(ch1),
        .external_trigger_input(ext_pin), .line_sync(line_pin),
        .trigger_path_view(trigger_path_view), .disp_addr(disp_addr),
        .disp_data(disp_data), .rec_ready(rec_ready));
    front_end_model fe (.hclk(hclk), .hresetn(hresetn), .wave_on(wave_on),
        .adc_valid(adc_valid), .adc_ch0(ch0), .adc_ch1(ch1),
        .external_trigger_input(ext_pin), .line_sync(line_pin));

    always #20 hclk = ~hclk;

    // Cycle budget and record counter; a hang ends as a mismatch
    always @(posedge hclk)
    begin
        cycles <= cycles + 1;
        if (rec_ready === 1'b1)
            recs <= recs + 1;
        if (cycles == 40000)
        begin
            fails++;
            print_verdict();
        end
    end

    task print_verdict();
        $display("checks %0d fails %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : print_verdict

    task check(input string what, input logic [31:0] exp,
        input logic [31:0] got);
        checks_done++;
        if (got !== exp)
        begin
            fails++;
            $display("[FAIL] %s exp %h got %h", what, exp, got);
        end
    endtask : check

    // No fixed latency assumed; the global budget bounds the wait
    task wait_ready();
        do @(posedge hclk); while (hreadyout !== 1'b1);
    endtask : wait_ready

    task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge hclk);
        haddr <= {24'h0, a};
        hwrite <= w;
        htrans <= 2'h2;
        wait_ready();
        htrans <= 2'h0;
        hwdata <= d;
        wait_ready();
        rd = hrdata;
    endtask : xfer

    task wait_rec(input int n);
        int r0;
        r0 = recs;
        for (int i = 0; i < n && recs == r0; i++)
            @(posedge hclk);
        seen = recs != r0;
    endtask : wait_rec

    task t_reset();
        xfer(0, `REG_LEVEL, 0);
        check("level", {24'h0, `LEVEL_RST}, rd);
        xfer(0, `REG_TIMEBASE, 0);
        check("timebase", 32'h1, rd);
        xfer(0, `REG_HPOS, 0);
        check("hpos", 32'h4e2, rd);
        xfer(0, `REG_RATE, 0);
        check("rate", 32'h3e8, rd);
        xfer(0, 8'h3c, 0);
        check("unmapped", 32'h0, rd);
    endtask : t_reset

    // Line source is only legal with edge type
    task t_refuse();
        for (int t = 0; t < 3; t++)
        begin
            xfer(1, `REG_CTRL, 32'h18 | (t << 1));
            xfer(0, `REG_CTRL, 0);
            check("ctrl src", (t == 0) ? 32'h3 : 32'h0, rd[4:3]);
            check("ctrl type", 32'(t), rd[2:1]);
        end
        xfer(1, `REG_TIMEBASE, 0);
        xfer(0, `REG_TIMEBASE, 0);
        check("tb zero", 32'h1, rd);
        xfer(1, `REG_HPOS, 32'hfff);
        xfer(0, `REG_HPOS, 0);
        check("hpos clip", 32'h9c3, rd);
    endtask : t_refuse

    // Normal single shot: waits in ready until a falling edge arrives
    task t_normal();
        wave_on <= 1'b0;
        xfer(1, `REG_HPOS, 32'ha);
        xfer(1, `REG_CTRL, 32'h21);
        xfer(1, `REG_CMD, 32'h2);
        repeat (300) @(posedge hclk);
        xfer(0, `REG_STATUS, 0);
        check("ready", 32'h4, rd[5:0]);
        check("no record", 32'h0, recs);
        wave_on <= 1'b1;
        wait_rec(6000);
        check("record", 32'h1, seen);
        xfer(0, `REG_STATUS, 0);
        check("done", 32'ha0, rd[7:0]);
        disp_addr <= 12'h5;
        repeat (3) @(posedge hclk);
        check("sample pad", 32'h0, disp_data & 32'hff00ff00);
        check("shared", {24'h0, ~disp_data[7:0]}, disp_data[23:16]);
    endtask : t_normal

    // Auto peak run with a flat input, then frequency and stop
    task t_auto();
        wave_on <= 1'b0;
        xfer(1, `REG_CTRL, 32'h80);
        xfer(1, `REG_CMD, 32'h1);
        wait_rec(6000);
        check("auto record", 32'h1, seen);
        repeat (2) @(posedge hclk);
        check("peak", 32'hefef1010, disp_data);
        wave_on <= 1'b1;
        repeat (2100) @(posedge hclk);
        xfer(0, `REG_TFREQ, 0);
        check("tfreq", 32'h1, rd >= 28 && rd <= 34);
        xfer(1, `REG_CMD, 32'h4);
        xfer(0, `REG_STATUS, 0);
        check("stopped", 32'h1, rd[5:0]);
    endtask : t_auto

    // Two flat records averaged must reproduce the input
    task t_avg();
        wave_on <= 1'b0;
        xfer(1, `REG_CTRL, 32'h300);
        xfer(1, `REG_CMD, 32'h1);
        wait_rec(12000);
        check("avg record", 32'h1, seen);
        repeat (2) @(posedge hclk);
        check("average", 32'h00ef0010, disp_data);
    endtask : t_avg

    task t_view();
        trigger_path_view <= 1'b1;
        repeat (6) @(posedge hclk);
        check("view", 32'h0, disp_data & 32'hffffff00);
        trigger_path_view <= 1'b0;
    endtask : t_view

    initial
    begin
        hclk = 1'b0;
        hresetn = 1'b0;
        htrans = 2'h0;
        haddr = 32'h0;
        hwrite = 1'b0;
        hwdata = 32'h0;
        trigger_path_view = 1'b0;
        disp_addr = 12'h0;
        wave_on = 1'b0;
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        t_reset();
        t_refuse();
        t_normal();
        t_auto();
        t_avg();
        t_view();
        print_verdict();
    end
endmodule : testbench
